// >>> inc/fieldbus_pkg.sv
// Constants and types of the fieldbus slave control block
package fieldbus_pkg;

  typedef enum logic [2:0] {
    ST_INIT, ST_PREOP, ST_SAFE_OPERATIONAL_STATE, ST_OP, ST_BOOT
  } state_type;

  localparam int          CLK_PERIOD_NS = 10;
  localparam int          DC_UNIT_NS    = 1;
  localparam logic [63:0] DC_STEP       = 64'(CLK_PERIOD_NS / DC_UNIT_NS);
  localparam logic [63:0] DC_RST        = 64'h0;

  localparam logic [15:0] IDX_DEVTYPE   = 16'h1000;
  localparam logic [15:0] IDX_IDENTITY  = 16'h1018;
  localparam logic [15:0] IDX_RX_MAP    = 16'h1600;
  localparam logic [15:0] IDX_TX_MAP    = 16'h1A00;
  localparam logic [15:0] IDX_PD_IN     = 16'h6000;
  localparam logic [15:0] IDX_PD_OUT    = 16'h7000;
  localparam logic [15:0] IDX_CHAN_BASE = 16'h8000;
  localparam logic [15:0] IDX_CHAN_ALT  = 16'h4000;
  localparam logic [15:0] IDX_SUPPRESS  = 16'hF008;
  localparam logic [3:0]  IDENT_REGION  = 4'h1;
  localparam int          CHAN_STRIDE   = 16;

  localparam logic [31:0] SUPPRESS_CODE = 32'h12345678;
  localparam logic [31:0] SUPPRESS_RST  = 32'h0;
  localparam logic [31:0] PARAM_RST     = 32'h0;
  // Identification values are arbitrary
  localparam logic [31:0] VENDOR_ID_DEF = 32'h0000_0A5A;
  localparam logic [31:0] PRODUCT_DEF   = 32'h0000_0101;
  localparam logic [31:0] DEVTYPE_DEF   = 32'h0000_0001;

endpackage

// >>> inc/par_if.sv
// Interface between dictionary control and channel parameter store
`timescale 1ns/1ns
interface par_if;
  logic [15:0] index;
  logic [7:0]  sub;
  logic [31:0] wdata;
  logic        wr;
  logic        hit;
  logic [31:0] rdata;

  modport ctrl  (output index, sub, wdata, wr, input hit, rdata);
  modport store (input index, sub, wdata, wr, output hit, rdata);
endinterface

// >>> verilog/param_store.sv
// Channel parameter store, sixteen indices per channel
`timescale 1ns/1ns
module param_store #(
  parameter int          NCH       = 2,
  parameter int          NSUB      = 8,
  parameter logic [15:0] CHAN_BASE = fieldbus_pkg::IDX_CHAN_BASE
) (
  input  wire logic i_sys_clk,
  input  wire logic i_nrst,
  par_if.store      bus
);
  localparam int DEPTH = NCH * fieldbus_pkg::CHAN_STRIDE * NSUB;
  localparam int AW    = $clog2(DEPTH);

  logic [31:0] mem_q [DEPTH];

  // Offset into the channel region: channel in upper, entry in low nibble
  wire logic [15:0] off = bus.index - CHAN_BASE;
  wire logic        in_region = (bus.index >= CHAN_BASE)
    && (off < 16'(NCH * fieldbus_pkg::CHAN_STRIDE));
  wire logic        sub_ok = (bus.sub < 8'(NSUB));
  wire logic [AW-1:0] addr =
    AW'(int'(off) * NSUB + int'(bus.sub));

  assign bus.hit   = in_region && sub_ok;
  assign bus.rdata = bus.hit ? mem_q[addr] : 32'h0;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= fieldbus_pkg::PARAM_RST;
      end
    end else if (bus.wr && bus.hit) begin
      mem_q[addr] <= bus.wdata;
    end
  end
endmodule

// >>> verilog/fieldbus_slave_ctrl.sv
// Fieldbus slave state gating, parameter dictionary and clock
`timescale 1ns/1ns
module fieldbus_slave_ctrl #(
  parameter int          PD_W      = 16,
  parameter int          NCH       = 2,
  parameter int          NSUB      = 8,
  parameter int          DC_W      = 64,
  parameter logic [15:0] CHAN_BASE = fieldbus_pkg::IDX_CHAN_BASE,
  parameter logic [PD_W-1:0] SAFE_OUT = '0,
  parameter logic [31:0] VENDOR_ID = fieldbus_pkg::VENDOR_ID_DEF,
  parameter logic [31:0] PRODUCT   = fieldbus_pkg::PRODUCT_DEF
) (
  input  wire logic            i_sys_clk,
  input  wire logic            i_nrst,

  input  wire logic            i_state_req_valid,
  input  wire logic [2:0]      i_state_req,
  output logic [2:0]           o_state,
  output logic                 o_state_ack,
  output logic                 o_state_refused,

  input  wire logic            i_mbx_valid,
  input  wire logic            i_mbx_file_access,
  output logic                 o_mbx_ack,
  output logic                 o_mbx_nak,

  input  wire logic            i_pd_valid,
  input  wire logic [PD_W-1:0] i_pd_out_data,
  input  wire logic [PD_W-1:0] i_in_data,
  input  wire logic            i_out_wdog_en,
  output logic                 o_pd_ack,
  output logic                 o_pd_nak,
  output logic [PD_W-1:0]      o_pd_in_data,
  output logic [PD_W-1:0]      o_outputs,

  input  wire logic            i_par_valid,
  input  wire logic            i_par_write,
  input  wire logic [15:0]     i_par_index,
  input  wire logic [7:0]      i_par_sub,
  input  wire logic [31:0]     i_par_wdata,
  output logic                 o_par_done,
  output logic                 o_par_err,
  output logic [31:0]          o_par_rdata,

  output logic                 o_nv_commit,
  output logic [15:0]          o_nv_index,
  output logic [7:0]           o_nv_sub,
  output logic [31:0]          o_nv_data,
  output logic                 o_suppress_active,

  input  wire logic            i_dc_set_valid,
  input  wire logic [63:0]     i_dc_set_value,
  output logic [63:0]          o_dc_time
);

  localparam logic [63:0] DC_MASK =
    (DC_W >= 64) ? 64'hFFFF_FFFF_FFFF_FFFF
                 : ((64'h1 << DC_W) - 64'h1);

  // Permitted state changes
  function automatic logic trans_ok(fieldbus_pkg::state_type cur,
                                    fieldbus_pkg::state_type req);
    logic ok;
    ok = 1'b0;
    unique case (cur)
      fieldbus_pkg::ST_INIT:
        ok = req inside {fieldbus_pkg::ST_INIT, fieldbus_pkg::ST_PREOP,
                         fieldbus_pkg::ST_BOOT};
      fieldbus_pkg::ST_PREOP:
        ok = req inside {fieldbus_pkg::ST_INIT, fieldbus_pkg::ST_PREOP,
                         fieldbus_pkg::ST_SAFE_OPERATIONAL_STATE};
      fieldbus_pkg::ST_SAFE_OPERATIONAL_STATE,
      fieldbus_pkg::ST_OP:
        ok = req inside {fieldbus_pkg::ST_INIT, fieldbus_pkg::ST_PREOP,
                         fieldbus_pkg::ST_SAFE_OPERATIONAL_STATE, fieldbus_pkg::ST_OP};
      fieldbus_pkg::ST_BOOT:
        ok = req inside {fieldbus_pkg::ST_INIT, fieldbus_pkg::ST_BOOT};
    endcase
    return ok;
  endfunction

  // Fixed identity and mapping entries, hit flag on top
  function automatic logic [32:0] ident_read(logic [15:0] idx,
                                             logic [7:0]  sub);
    logic [32:0] r;
    r = 33'h0;
    if (idx == fieldbus_pkg::IDX_DEVTYPE && sub == 8'h00) begin
      r = {1'b1, fieldbus_pkg::DEVTYPE_DEF};
    end else if (idx == fieldbus_pkg::IDX_IDENTITY) begin
      unique case (sub)
        8'h00:   r = {1'b1, 32'h0000_0002};
        8'h01:   r = {1'b1, VENDOR_ID};
        8'h02:   r = {1'b1, PRODUCT};
        default: r = 33'h0;
      endcase
    end else if ((idx == fieldbus_pkg::IDX_RX_MAP ||
                  idx == fieldbus_pkg::IDX_TX_MAP) && sub == 8'h00) begin
      r = {1'b1, 32'h0000_0001};
    end
    return r;
  endfunction

  fieldbus_pkg::state_type state_q;
  fieldbus_pkg::state_type state_d;
  fieldbus_pkg::state_type req_st;

  logic            st_ack_q;
  logic            st_ref_q;
  logic            mbx_ack_q;
  logic            mbx_nak_q;
  logic            pd_ack_q;
  logic            pd_nak_q;
  logic [PD_W-1:0] pd_in_q;
  logic [PD_W-1:0] out_buf_q;
  logic [PD_W-1:0] outputs_q;
  logic            par_done_q;
  logic            par_err_q;
  logic [31:0]     par_rdata_q;
  logic            nv_commit_q;
  logic [15:0]     nv_index_q;
  logic [7:0]      nv_sub_q;
  logic [31:0]     nv_data_q;
  logic [31:0]     supp_code_q;
  logic [31:0]     supp_code_d;
  logic            supp_act_q;
  logic [63:0]     dc_q;
  logic [63:0]     dc_d;

  par_if pbus ();

  param_store #(
    .NCH       (NCH),
    .NSUB      (NSUB),
    .CHAN_BASE (CHAN_BASE)
  ) u_store (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .bus       (pbus.store)
  );

  // State requests
  assign req_st = fieldbus_pkg::state_type'(i_state_req);
  wire logic req_ok = i_state_req_valid && trans_ok(state_q, req_st);
  assign state_d = req_ok ? req_st : state_q;

  wire logic in_init = (state_q == fieldbus_pkg::ST_INIT);
  wire logic in_safe = (state_q == fieldbus_pkg::ST_SAFE_OPERATIONAL_STATE);
  wire logic in_op   = (state_q == fieldbus_pkg::ST_OP);
  wire logic in_boot = (state_q == fieldbus_pkg::ST_BOOT);

  // Mailbox gating: none in init, file access only in boot
  wire logic mbx_full = !in_init && !in_boot;
  wire logic mbx_open = mbx_full || (in_boot && i_mbx_file_access);

  // Process data gating and output drive
  wire logic pd_open  = in_safe || in_op;
  wire logic drive_en = in_op || (in_safe && !i_out_wdog_en);
  wire logic [PD_W-1:0] outputs_d =
    drive_en ? out_buf_q : SAFE_OUT;

  // Dictionary decode
  wire logic [32:0] ident = ident_read(i_par_index, i_par_sub);
  wire logic ident_hit = ident[32];
  wire logic ro_region =
    (i_par_index[15:12] == fieldbus_pkg::IDENT_REGION);
  wire logic pdin_hit = (i_par_index == fieldbus_pkg::IDX_PD_IN)
    && (i_par_sub <= 8'h01);
  wire logic pdout_hit = (i_par_index == fieldbus_pkg::IDX_PD_OUT)
    && (i_par_sub <= 8'h01);
  wire logic supp_hit = (i_par_index == fieldbus_pkg::IDX_SUPPRESS)
    && (i_par_sub == 8'h00);
  wire logic chan_hit = pbus.hit;
  wire logic mapped = ident_hit || pdin_hit || pdout_hit
    || supp_hit || chan_hit;
  wire logic writable = (chan_hit || supp_hit) && !ro_region;
  wire logic par_err = !mbx_full || !mapped
    || (i_par_write && !writable);
  wire logic par_wr = i_par_valid && i_par_write && !par_err;
  wire logic chan_wr = par_wr && chan_hit;

  assign pbus.index = i_par_index;
  assign pbus.sub   = i_par_sub;
  assign pbus.wdata = i_par_wdata;
  assign pbus.wr    = chan_wr;

  wire logic [31:0] count_one = 32'h0000_0001;
  wire logic [31:0] rdata_d =
    chan_hit  ? pbus.rdata :
    supp_hit  ? supp_code_q :
    ident_hit ? ident[31:0] :
    pdin_hit  ? ((i_par_sub == 8'h00) ? count_one : 32'(pd_in_q)) :
    pdout_hit ? ((i_par_sub == 8'h00) ? count_one : 32'(out_buf_q)) :
                32'h0;

  assign supp_code_d = (par_wr && supp_hit) ? i_par_wdata
                                            : supp_code_q;

  // Clock counter with master correction
  assign dc_d = i_dc_set_valid ? (i_dc_set_value & DC_MASK)
    : ((dc_q + fieldbus_pkg::DC_STEP) & DC_MASK);

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q  <= fieldbus_pkg::ST_INIT;
      st_ack_q <= 1'b0;
      st_ref_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      st_ack_q <= req_ok;
      st_ref_q <= i_state_req_valid && !req_ok;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mbx_ack_q <= 1'b0;
      mbx_nak_q <= 1'b0;
      pd_ack_q  <= 1'b0;
      pd_nak_q  <= 1'b0;
    end else begin
      mbx_ack_q <= i_mbx_valid && mbx_open;
      mbx_nak_q <= i_mbx_valid && !mbx_open;
      pd_ack_q  <= i_pd_valid && pd_open;
      pd_nak_q  <= i_pd_valid && !pd_open;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pd_in_q   <= '0;
      out_buf_q <= SAFE_OUT;
      outputs_q <= SAFE_OUT;
    end else begin
      if (pd_open) begin
        pd_in_q <= i_in_data;
      end
      if (i_pd_valid && pd_open) begin
        out_buf_q <= i_pd_out_data;
      end
      outputs_q <= outputs_d;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      par_done_q  <= 1'b0;
      par_err_q   <= 1'b0;
      par_rdata_q <= 32'h0;
    end else begin
      par_done_q <= i_par_valid;
      par_err_q  <= i_par_valid && par_err;
      if (i_par_valid && !i_par_write && !par_err) begin
        par_rdata_q <= rdata_d;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      nv_commit_q <= 1'b0;
      nv_index_q  <= 16'h0;
      nv_sub_q    <= 8'h0;
      nv_data_q   <= 32'h0;
    end else begin
      nv_commit_q <= chan_wr && !supp_act_q;
      if (chan_wr) begin
        nv_index_q <= i_par_index;
        nv_sub_q   <= i_par_sub;
        nv_data_q  <= i_par_wdata;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      supp_code_q <= fieldbus_pkg::SUPPRESS_RST;
      supp_act_q  <= 1'b0;
      dc_q        <= fieldbus_pkg::DC_RST;
    end else begin
      supp_code_q <= supp_code_d;
      supp_act_q  <= (supp_code_d == fieldbus_pkg::SUPPRESS_CODE);
      dc_q        <= dc_d;
    end
  end

  assign o_state           = state_q;
  assign o_state_ack       = st_ack_q;
  assign o_state_refused   = st_ref_q;
  assign o_mbx_ack         = mbx_ack_q;
  assign o_mbx_nak         = mbx_nak_q;
  assign o_pd_ack          = pd_ack_q;
  assign o_pd_nak          = pd_nak_q;
  assign o_pd_in_data      = pd_in_q;
  assign o_outputs         = outputs_q;
  assign o_par_done        = par_done_q;
  assign o_par_err         = par_err_q;
  assign o_par_rdata       = par_rdata_q;
  assign o_nv_commit       = nv_commit_q;
  assign o_nv_index        = nv_index_q;
  assign o_nv_sub          = nv_sub_q;
  assign o_nv_data         = nv_data_q;
  assign o_suppress_active = supp_act_q;
  assign o_dc_time         = dc_q;

  // Checks
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence op_write_s;
    i_pd_valid && in_op ##1 in_op;
  endsequence

  sequence chan_wr_s;
    chan_wr;
  endsequence

  init_mbx_quiet_a: assert property (
    (in_init && i_mbx_valid) |=> (o_mbx_nak && !o_mbx_ack))
    else $error("mailbox accepted in initial state");

  safe_input_update_a: assert property (
    in_safe |=> (o_pd_in_data == $past(i_in_data)))
    else $error("inputs not updated in safe state");

  safe_outputs_held_a: assert property (
    (in_safe && i_out_wdog_en) |=> (o_outputs == SAFE_OUT))
    else $error("outputs driven while watchdog on");

  wdog_off_drive_a: assert property (
    (in_safe && !i_out_wdog_en) |=> (o_outputs == $past(out_buf_q)))
    else $error("outputs not driven with watchdog off");

  op_copy_out_a: assert property (
    op_write_s |=> (o_outputs == $past(i_pd_out_data, 2)))
    else $error("operational outputs not copied");

  boot_entry_only_a: assert property (
    (!in_init && !in_boot) |=> (state_q != fieldbus_pkg::ST_BOOT))
    else $error("boot state entered from wrong state");

  boot_mbx_filter_a: assert property (
    (in_boot && i_mbx_valid) |=> (o_mbx_ack == $past(i_mbx_file_access)))
    else $error("wrong mailbox service in boot");

  fixed_ro_write_a: assert property (
    (i_par_valid && i_par_write && ro_region) |=> (o_par_done && o_par_err))
    else $error("fixed entry write not refused");

  nv_commit_write_a: assert property (
    (chan_wr_s and !supp_act_q) |=>
      (o_nv_commit && o_nv_data == $past(i_par_wdata)))
    else $error("changed parameter not committed");

  suppress_commit_a: assert property (
    (chan_wr_s and supp_act_q) |=> (!o_nv_commit && !o_par_err))
    else $error("commit while suppression active");

  suppress_arm_a: assert property (
    (par_wr && supp_hit && i_par_wdata == fieldbus_pkg::SUPPRESS_CODE)
      |=> o_suppress_active)
    else $error("suppression code did not arm");

  dc_tick_a: assert property (
    !i_dc_set_valid |=>
      (o_dc_time == (($past(o_dc_time) + fieldbus_pkg::DC_STEP) & DC_MASK)))
    else $error("clock did not advance one period");

  dc_correct_a: assert property (
    i_dc_set_valid |=> (o_dc_time == ($past(i_dc_set_value) & DC_MASK)))
    else $error("clock correction not taken");

  state_refuse_a: assert property (
    (i_state_req_valid && !req_ok) |=> (o_state_refused && $stable(o_state)))
    else $error("illegal state change not refused");

endmodule

// >>> test/fieldbus_master_model.sv
// Behavioural fieldbus master driving the slave control block
`timescale 1ns/1ns
module fieldbus_master_model #(
  parameter int PD_W = 16
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_go,
  input  wire logic [2:0]  i_kind,
  input  wire logic [63:0] i_arg,
  input  wire logic [15:0] i_idx,
  input  wire logic [7:0]  i_sub,
  input  wire logic        i_flag,
  output logic             o_done,
  output logic             o_state_req_valid,
  output logic [2:0]       o_state_req,
  output logic             o_mbx_valid,
  output logic             o_mbx_file_access,
  output logic             o_pd_valid,
  output logic [PD_W-1:0]  o_pd_out_data,
  output logic [PD_W-1:0]  o_in_data,
  output logic             o_out_wdog_en,
  output logic             o_par_valid,
  output logic             o_par_write,
  output logic [15:0]      o_par_index,
  output logic [7:0]       o_par_sub,
  output logic [31:0]      o_par_wdata,
  output logic             o_dc_set_valid,
  output logic [63:0]      o_dc_set_value
);
  logic out_sent;

  initial begin
    {o_state_req_valid, o_state_req, o_mbx_valid, o_mbx_file_access} = '0;
    {o_pd_valid, o_pd_out_data, o_in_data, o_out_wdog_en} = '0;
    {o_par_valid, o_par_write, o_par_index, o_par_sub, o_par_wdata} = '0;
    {o_dc_set_valid, o_dc_set_value} = '0;
    out_sent = 1'b0;
    o_done   = 1'b0;
  end

  // Released data flips (par index, sub and write are held) so stale values never look valid
  task automatic state_cmd(input logic [2:0] code);
    if (code == 3'h3 && !out_sent) begin
      pd_cmd(o_pd_out_data);
    end
    @(negedge i_sys_clk);
    o_state_req_valid = 1'b1;
    o_state_req       = code;
    @(negedge i_sys_clk);
    o_state_req_valid = 1'b0;
    o_state_req       = ~code;
  endtask

  task automatic mbx_cmd(input logic file_acc);
    @(negedge i_sys_clk);
    o_mbx_valid       = 1'b1;
    o_mbx_file_access = file_acc;
    @(negedge i_sys_clk);
    o_mbx_valid       = 1'b0;
    o_mbx_file_access = ~file_acc;
  endtask

  task automatic pd_cmd(input logic [PD_W-1:0] data);
    @(negedge i_sys_clk);
    o_pd_valid    = 1'b1;
    o_pd_out_data = data;
    out_sent      = 1'b1;
    @(negedge i_sys_clk);
    o_pd_valid    = 1'b0;
    o_pd_out_data = ~data;
  endtask

  task automatic par_cmd(input logic wr, input logic [15:0] idx,
                         input logic [7:0] sub, input logic [31:0] data);
    @(negedge i_sys_clk);
    o_par_valid = 1'b1;
    o_par_write = wr;
    o_par_index = idx;
    o_par_sub   = sub;
    o_par_wdata = data;
    @(negedge i_sys_clk);
    o_par_valid = 1'b0;
    o_par_wdata = ~data;
  endtask

  task automatic dc_cmd(input logic [63:0] value);
    @(negedge i_sys_clk);
    o_dc_set_valid = 1'b1;
    o_dc_set_value = value;
    @(negedge i_sys_clk);
    o_dc_set_valid = 1'b0;
    o_dc_set_value = ~value;
  endtask

  task automatic levels(input logic wdog, input logic [PD_W-1:0] in_data);
    @(negedge i_sys_clk);
    o_out_wdog_en = wdog;
    o_in_data     = in_data;
  endtask

  // Each toggle of the go line runs one transfer, then toggles done
  always @(i_go) begin
    if (!$isunknown(i_kind)) begin
      unique case (i_kind)
        3'h0:    state_cmd(i_arg[2:0]);
        3'h1:    mbx_cmd(i_flag);
        3'h2:    pd_cmd(i_arg[PD_W-1:0]);
        3'h3:    par_cmd(i_flag, i_idx, i_sub, i_arg[31:0]);
        3'h4:    dc_cmd(i_arg);
        default: levels(i_flag, i_arg[PD_W-1:0]);
      endcase
      o_done = ~o_done;
    end
  end
endmodule

// >>> test/fieldbus_slave_state_param_dictionary_tb.sv
// Self-checking bench of the fieldbus slave control block
`timescale 1ns/1ns
module fieldbus_slave_state_param_dictionary_tb;
  typedef struct packed {
    logic [2:0] req;
    logic [2:0] st;
    logic       ack;
  } row_type;
  logic        clk;
  logic        nrst;
  logic        sv, mv, mf, pv, wd, av, aw, dv;
  logic [2:0]  sr, st;
  logic [15:0] pdo, ind, ai, pin, outs, ni;
  logic [7:0]  as, ns;
  logic [31:0] ad, rd, nd;
  logic [63:0] dcv, dct;
  logic        sa, srf, ma, mn, pa, pn, pd, pe, nc, sup;
  int          fail_count;
  int          total_checks;
  row_type     rows [11];
  logic        go, go_flag, done;
  logic [2:0]  go_kind;
  logic [63:0] go_arg;
  logic [15:0] go_idx;
  logic [7:0]  go_sub;

  fieldbus_master_model fieldbus_master_model_inst (
    .i_sys_clk(clk), .i_go(go), .i_kind(go_kind), .i_arg(go_arg),
    .i_idx(go_idx), .i_sub(go_sub), .i_flag(go_flag), .o_done(done),
    .o_state_req_valid(sv), .o_state_req(sr),
    .o_mbx_valid(mv), .o_mbx_file_access(mf), .o_pd_valid(pv),
    .o_pd_out_data(pdo), .o_in_data(ind), .o_out_wdog_en(wd),
    .o_par_valid(av), .o_par_write(aw), .o_par_index(ai), .o_par_sub(as),
    .o_par_wdata(ad), .o_dc_set_valid(dv), .o_dc_set_value(dcv));

  fieldbus_slave_ctrl fieldbus_slave_ctrl_inst (
    .i_sys_clk(clk), .i_nrst(nrst), .i_state_req_valid(sv),
    .i_state_req(sr), .o_state(st), .o_state_ack(sa),
    .o_state_refused(srf), .i_mbx_valid(mv), .i_mbx_file_access(mf),
    .o_mbx_ack(ma), .o_mbx_nak(mn), .i_pd_valid(pv), .i_pd_out_data(pdo),
    .i_in_data(ind), .i_out_wdog_en(wd), .o_pd_ack(pa), .o_pd_nak(pn),
    .o_pd_in_data(pin), .o_outputs(outs), .i_par_valid(av),
    .i_par_write(aw), .i_par_index(ai), .i_par_sub(as), .i_par_wdata(ad),
    .o_par_done(pd), .o_par_err(pe), .o_par_rdata(rd), .o_nv_commit(nc),
    .o_nv_index(ni), .o_nv_sub(ns), .o_nv_data(nd),
    .o_suppress_active(sup), .i_dc_set_valid(dv), .i_dc_set_value(dcv),
    .o_dc_time(dct));

  initial begin
    clk = 1'b0;
  end
  always #5 clk = ~clk;

  task automatic check(input string name, input logic [63:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic run(input logic [2:0] kind, input logic [63:0] arg,
                     input logic [15:0] idx, input logic [7:0] sub,
                     input logic flag);
    go_kind = kind;
    go_arg  = arg;
    go_idx  = idx;
    go_sub  = sub;
    go_flag = flag;
    go      = ~go;
    @(done);
  endtask

  task automatic state_cmd(input logic [2:0] code);
    run(3'h0, 64'(code), 16'h0, 8'h0, 1'b0);
  endtask

  task automatic mbx_cmd(input logic fa);
    run(3'h1, 64'h0, 16'h0, 8'h0, fa);
  endtask

  task automatic pd_cmd(input logic [15:0] data);
    run(3'h2, 64'(data), 16'h0, 8'h0, 1'b0);
  endtask

  task automatic dc_cmd(input logic [63:0] v);
    run(3'h4, v, 16'h0, 8'h0, 1'b0);
  endtask

  task automatic levels(input logic wdog, input logic [15:0] in_data);
    run(3'h5, 64'(in_data), 16'h0, 8'h0, wdog);
  endtask

  task automatic par(input logic w, input logic [15:0] i,
                     input logic [7:0] s, input logic [31:0] d,
                     input logic e);
    run(3'h3, 64'(d), i, s, w);
    check("par_done", pd, 1'b1);
    check("par_err", pe, e);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    end_of_test;
  end

  initial begin
    fail_count   = 0;
    total_checks = 0;
    nrst         = 1'b0;
    go           = 1'b0;
    rows = '{'{3'h4, 3'h4, 1'b1}, '{3'h1, 3'h4, 1'b0}, '{3'h0, 3'h0, 1'b1},
             '{3'h3, 3'h0, 1'b0}, '{3'h7, 3'h0, 1'b0}, '{3'h5, 3'h0, 1'b0},
             '{3'h1, 3'h1, 1'b1}, '{3'h4, 3'h1, 1'b0}, '{3'h2, 3'h2, 1'b1},
             '{3'h3, 3'h3, 1'b1}, '{3'h0, 3'h0, 1'b1}};
    repeat (20) @(negedge clk);
    check("state", st, 3'h0);
    check("outputs", outs, 16'h0);
    check("suppress", sup, 1'b0);
    check("dc_time", dct, 64'h0);
    nrst = 1'b1;
    mbx_cmd(1'b1);
    check("mbx_nak", mn, 1'b1);
    pd_cmd(16'h00FF);
    check("pd_nak", pn, 1'b1);
    par(1'b0, 16'h1000, 8'h00, 32'h0, 1'b1);
    $display("reset and init test done");

    foreach (rows[k]) begin
      state_cmd(rows[k].req);
      check("state", st, rows[k].st);
      check("ack", sa, rows[k].ack);
      check("refused", srf, !rows[k].ack);
    end
    $display("state table test done");

    state_cmd(3'h4);
    mbx_cmd(1'b1);
    check("mbx_ack", ma, 1'b1);
    mbx_cmd(1'b0);
    check("mbx_nak", mn, 1'b1);
    pd_cmd(16'h0F0F);
    check("pd_nak", pn, 1'b1);
    state_cmd(3'h0);
    $display("firmware update test done");

    state_cmd(3'h1);
    par(1'b1, 16'h8010, 8'h03, 32'hCAFE_0123, 1'b0);
    check("nv_commit", nc, 1'b1);
    check("nv_index", ni, 16'h8010);
    check("nv_sub", ns, 8'h03);
    check("nv_data", nd, 32'hCAFE_0123);
    par(1'b0, 16'h8010, 8'h03, 32'h0, 1'b0);
    check("rdata", rd, 32'hCAFE_0123);
    par(1'b1, 16'h1018, 8'h01, 32'h5, 1'b1);
    par(1'b0, 16'h1018, 8'h00, 32'h0, 1'b0);
    check("rdata", rd, 32'h2);
    par(1'b0, 16'h801F, 8'h07, 32'h0, 1'b0);
    par(1'b0, 16'h8020, 8'h00, 32'h0, 1'b1);
    par(1'b0, 16'h6000, 8'h00, 32'h0, 1'b0);
    check("rdata", rd, 32'h1);
    par(1'b0, 16'h7000, 8'h00, 32'h0, 1'b0);
    check("rdata", rd, 32'h1);
    par(1'b0, 16'hFFFF, 8'hFF, 32'h0, 1'b1);
    $display("dictionary test done");

    par(1'b1, fieldbus_pkg::IDX_SUPPRESS, 8'h00,
        fieldbus_pkg::SUPPRESS_CODE, 1'b0);
    check("suppress", sup, 1'b1);
    par(1'b1, 16'h8000, 8'h05, 32'h0BAD_F00D, 1'b0);
    check("nv_commit", nc, 1'b0);
    par(1'b0, 16'h8000, 8'h05, 32'h0, 1'b0);
    check("rdata", rd, 32'h0BAD_F00D);
    par(1'b1, fieldbus_pkg::IDX_SUPPRESS, 8'h00, 32'h0, 1'b0);
    check("suppress", sup, 1'b0);
    $display("suppression test done");

    state_cmd(3'h2);
    levels(1'b1, 16'hA5C3);
    pd_cmd(16'h1234);
    check("pd_ack", pa, 1'b1);
    @(negedge clk);
    check("outputs", outs, 16'h0);
    check("pd_in", pin, 16'hA5C3);
    levels(1'b0, 16'h3C5A);
    @(negedge clk);
    check("outputs", outs, 16'h1234);
    check("pd_in", pin, 16'h3C5A);
    levels(1'b1, 16'h3C5A);
    state_cmd(3'h3);
    pd_cmd(16'hBEEF);
    check("pd_ack", pa, 1'b1);
    @(negedge clk);
    check("outputs", outs, 16'hBEEF);
    mbx_cmd(1'b0);
    check("mbx_ack", ma, 1'b1);
    $display("process data test done");

    dc_cmd(64'hFFFF_FFFF_FFFF_FFF6);
    check("dc_time", dct, 64'hFFFF_FFFF_FFFF_FFF6);
    @(negedge clk);
    check("dc_time", dct, 64'h0);
    $display("clock test done");

    par(1'b1, fieldbus_pkg::IDX_SUPPRESS, 8'h00,
        fieldbus_pkg::SUPPRESS_CODE, 1'b0);
    check("suppress", sup, 1'b1);
    nrst = 1'b0;
    @(negedge clk);
    check("suppress", sup, 1'b0);
    check("state", st, 3'h0);
    check("outputs", outs, 16'h0);
    nrst = 1'b1;
    mbx_cmd(1'b0);
    check("mbx_nak", mn, 1'b1);
    $display("restart test done");
    end_of_test;
  end
endmodule
